/* src/fsl_pkg.sv */
// Package for fault status and limiter control block
package fsl_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_L_MODE = 8'h0E;
    localparam logic [7:0] ADDR_L_THR = 8'h0F;
    localparam logic [7:0] ADDR_L_INF = 8'h10;
    localparam logic [7:0] ADDR_R_MODE = 8'h11;
    localparam logic [7:0] ADDR_R_THR = 8'h12;
    localparam logic [7:0] ADDR_R_INF = 8'h13;
    localparam logic [7:0] ADDR_L_CLIP = 8'h14;
    localparam logic [7:0] ADDR_R_CLIP = 8'h15;
    localparam logic [7:0] ADDR_OTW_GAIN = 8'h16;
    localparam logic [7:0] ADDR_RECOVERY = 8'h17;
    localparam logic [7:0] ADDR_STATUS0 = 8'h18;
    localparam logic [7:0] ADDR_STATUS1 = 8'h19;
    localparam logic [7:0] ADDR_VBAT = 8'h1A;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_L_MODE = 8'hA0;
    localparam logic [7:0] RST_R_MODE = 8'hA8;
    localparam logic [7:0] RST_THR = 8'h51;
    localparam logic [7:0] RST_INF = 8'h22;
    localparam logic [7:0] RST_CLIP = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_REG_UV = 6;
    localparam int B_SUP_UV = 7;
    localparam int B_OTF = 1;
    localparam int B_OTW = 0;
    localparam int B_TRACK = 2;
    localparam int B_MANUAL_RECOVERY_REQUEST = 7;
    localparam int B_UNDERVOLT_RECOVERY_SELECT = 2;
    localparam int B_OVERTEMP_RECOVERY_SELECT = 1;
    localparam int B_OVERCURRENT_RECOVERY_SELECT = 0;
    localparam int B_RETRY_LO = 4;
    localparam int B_THR_LO = 3;
    localparam int B_ATK_LO = 4;
    localparam int B_REL_LO = 6;
    localparam int B_GAIN_R_LO = 4;
    localparam int CH_RIGHT_OFS = 4;
    // ------------------------------------------------------------
    // Limiter modes and timing
    // ------------------------------------------------------------
    localparam logic [1:0] LIM_OFF = 2'b00;
    localparam logic [1:0] LIM_ALWAYS = 2'b01;
    localparam logic [1:0] LIM_MUTE_LOW = 2'b10;
    localparam logic [1:0] LIM_LOW_ONLY = 2'b11;
    localparam logic [7:0] INF_HYST = 8'h04;
    localparam logic [7:0] VBAT_SPAN_MIN = 8'h00;
    localparam int RETRY_DELAY_US = 100;
    localparam int CLK_MHZ = 125;
    localparam int RETRY_CYC = RETRY_DELAY_US * CLK_MHZ;
    localparam int RATE_BASE_LOG2 = 4;
    typedef enum logic [1:0] {FSL_RUN, FSL_WAIT, FSL_DOWN} fsl_state_t;
endpackage

/* src/fsl_ctrl.sv */
// Fault status, recovery and per-channel limiter control
`timescale 1ns/100ps
module fsl_ctrl #(
    parameter int RETRY_CYCLES = fsl_pkg::RETRY_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Analog monitor pins
    input wire logic regulator_uv_i,
    input wire logic supply_uv_i,
    input wire logic overtemp_fault_i,
    input wire logic overtemp_warn_i,
    input wire logic [1:0] overcurrent_i,
    input wire logic [1:0] dac_clip_i,
    input wire logic [7:0] vbat_code_i,
    // Per-channel signal level, threshold units
    input wire logic [4:0] left_level_i,
    input wire logic [4:0] right_level_i,
    // Outputs to the power stage and gain path
    output logic amp_enable_o,
    output logic [1:0] mute_o,
    output logic [7:0] left_gain_cut_o,
    output logic [7:0] right_gain_cut_o,
    output logic [1:0] left_warning_gain_cut_o,
    output logic [1:0] right_warning_gain_cut_o,
    output logic [7:0] left_clipper_level_o,
    output logic [7:0] right_clipper_level_o
);
    import fsl_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [15:0] sync1_q;
    logic [15:0] sync2_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {regulator_uv_i, supply_uv_i, overtemp_fault_i, overtemp_warn_i,
                        overcurrent_i, dac_clip_i, vbat_code_i};
            sync2_q <= sync1_q;
        end
    end
    logic s_reg_uv, s_sup_uv, s_otf, s_otw;
    logic [1:0] s_oc, s_clip;
    logic [7:0] s_vbat;
    assign {s_reg_uv, s_sup_uv, s_otf, s_otw, s_oc, s_clip, s_vbat} = sync2_q;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] l_mode_q, l_thr_q, l_inf_q, r_mode_q, r_thr_q, r_inf_q;
    logic [7:0] l_clip_q, r_clip_q, otw_gain_q, recov_q;
    logic [7:0] vbat_q;
    logic manual_recovery_request_pulse_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            l_mode_q <= RST_L_MODE;
            l_thr_q <= RST_THR;
            l_inf_q <= RST_INF;
            r_mode_q <= RST_R_MODE;
            r_thr_q <= RST_THR;
            r_inf_q <= RST_INF;
            l_clip_q <= RST_CLIP;
            r_clip_q <= RST_CLIP;
            otw_gain_q <= RST_ZERO;
            recov_q <= RST_ZERO;
            manual_recovery_request_pulse_q <= 1'b0;
        end else begin
            manual_recovery_request_pulse_q <= reg_wr_i && reg_addr_i == ADDR_RECOVERY
                && reg_wdata_i[B_MANUAL_RECOVERY_REQUEST];
            if (reg_wr_i) begin
                case (reg_addr_i)
                    ADDR_L_MODE: l_mode_q <= reg_wdata_i;
                    ADDR_L_THR: l_thr_q <= reg_wdata_i;
                    ADDR_L_INF: l_inf_q <= reg_wdata_i;
                    ADDR_R_MODE: r_mode_q <= reg_wdata_i;
                    ADDR_R_THR: r_thr_q <= reg_wdata_i;
                    ADDR_R_INF: r_inf_q <= reg_wdata_i;
                    ADDR_L_CLIP: l_clip_q <= reg_wdata_i;
                    ADDR_R_CLIP: r_clip_q <= reg_wdata_i;
                    ADDR_OTW_GAIN: otw_gain_q <= reg_wdata_i;
                    // Request bit is self clearing, never stored
                    ADDR_RECOVERY: recov_q <= {1'b0, reg_wdata_i[6:0]};
                    default: ;
                endcase
            end
        end
    end

    // Supply code latch
    // A multi-bit code is taken only once two synced samples agree
    logic [7:0] vbat_prev_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            vbat_q <= RST_ZERO;
            vbat_prev_q <= RST_ZERO;
        end else begin
            vbat_prev_q <= s_vbat;
            if (s_vbat == vbat_prev_q) vbat_q <= s_vbat;
        end
    end

    // ------------------------------------------------------------
    // Fault recovery
    // ------------------------------------------------------------
    wire uv_fault = s_reg_uv | s_sup_uv;
    wire oc_fault = |s_oc;
    // A class counts as manual when its select bit is low
    wire uv_auto = recov_q[B_UNDERVOLT_RECOVERY_SELECT];
    wire ot_auto = recov_q[B_OVERTEMP_RECOVERY_SELECT];
    wire oc_auto = recov_q[B_OVERCURRENT_RECOVERY_SELECT];
    wire any_fault = uv_fault | s_otf | oc_fault;
    wire manual_hit = (uv_fault & ~uv_auto) | (s_otf & ~ot_auto) | (oc_fault & ~oc_auto);
    wire [1:0] retry_max = recov_q[B_RETRY_LO +: 2];

    fsl_state_t st_q;
    logic [31:0] wait_q;
    logic [1:0] tries_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= FSL_RUN;
            wait_q <= '0;
            tries_q <= '0;
        end else begin
            case (st_q)
                FSL_RUN: begin
                    if (manual_hit) begin
                        st_q <= FSL_DOWN;
                    end else if (any_fault) begin
                        st_q <= FSL_WAIT;
                        wait_q <= '0;
                    end
                end
                FSL_WAIT: begin
                    if (manual_hit) begin
                        st_q <= FSL_DOWN;
                    end else if (wait_q == 32'(RETRY_CYCLES - 1)) begin
                        wait_q <= '0;
                        if (!any_fault) begin
                            st_q <= FSL_RUN;
                            tries_q <= '0;
                        end else if (tries_q >= retry_max) begin
                            st_q <= FSL_DOWN;
                        end else begin
                            tries_q <= tries_q + 2'd1;
                        end
                    end else begin
                        wait_q <= wait_q + 32'd1;
                    end
                end
                FSL_DOWN: begin
                    if (manual_recovery_request_pulse_q) begin
                        st_q <= FSL_WAIT;
                        wait_q <= '0;
                        tries_q <= '0;
                    end
                end
                default: st_q <= FSL_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Limiter per channel
    // ------------------------------------------------------------
    // Threshold lowered by slope plus one times supply drop, divided by eight
    function automatic logic [4:0] track_thr(input logic [4:0] thr, input logic [1:0] slope,
                                             input logic [7:0] inf, input logic [7:0] vb);
        logic [10:0] drop;
        // No drop inside the hysteresis band above the point
        drop = (inf > vb) ? (11'(inf - vb) * 11'({1'b0, slope} + 3'd1)) >> 3 : 11'd0;
        track_thr = (drop >= 11'(thr)) ? 5'd0 : 5'(11'(thr) - drop);
    endfunction

    logic [1:0] engaged_q;
    logic [1:0] low_q;
    logic [1:0] mute_q;
    logic [7:0] cut_q [2];
    logic [7:0] rate_q [2];
    wire [7:0] mode_r [2] = '{l_mode_q, r_mode_q};
    wire [7:0] thr_r [2] = '{l_thr_q, r_thr_q};
    wire [7:0] inf_r [2] = '{l_inf_q, r_inf_q};
    wire [4:0] lvl [2] = '{left_level_i, right_level_i};

    for (genvar c = 0; c < 2; c++) begin : g_ch
        wire [1:0] mode = mode_r[c][1:0];
        wire below = vbat_q < inf_r[c];
        // Leaving the low state needs the supply well above the point
        wire rise = {1'b0, vbat_q} > {1'b0, inf_r[c]} + {1'b0, INF_HYST};
        wire low_n = low_q[c] ? ~rise : below;
        wire [4:0] set_thr = thr_r[c][B_THR_LO +: 5];
        wire [4:0] eff_thr = (mode_r[c][B_TRACK] && low_n)
            ? track_thr(set_thr, thr_r[c][1:0], inf_r[c], vbat_q) : set_thr;
        logic active;
        always_comb begin
            case (mode)
                LIM_OFF: active = 1'b0;
                LIM_ALWAYS: active = 1'b1;
                LIM_MUTE_LOW: active = ~low_n;
                LIM_LOW_ONLY: active = low_n;
                default: active = 1'b0;
            endcase
        end
        wire over = active && lvl[c] > eff_thr;
        wire [1:0] atk = mode_r[c][B_ATK_LO +: 2];
        wire [1:0] rel = mode_r[c][B_REL_LO +: 2];
        wire [7:0] step_t = 8'(1) << (over ? atk : rel);
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                low_q[c] <= 1'b0;
                engaged_q[c] <= 1'b0;
                mute_q[c] <= 1'b0;
                cut_q[c] <= RST_ZERO;
                rate_q[c] <= RST_ZERO;
            end else begin
                low_q[c] <= low_n;
                engaged_q[c] <= over;
                mute_q[c] <= mode == LIM_MUTE_LOW && low_n;
                rate_q[c] <= rate_q[c] + 8'd1;
                // Gain steps at a rate picked by attack or release field
                if (rate_q[c][RATE_BASE_LOG2 +: 4] == 4'(step_t) || step_t > 8'd15) begin
                    rate_q[c] <= RST_ZERO;
                    if (over && cut_q[c] != 8'hFF) cut_q[c] <= cut_q[c] + 8'd1;
                    else if (!over && cut_q[c] != RST_ZERO) cut_q[c] <= cut_q[c] - 8'd1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status registers and outputs
    // ------------------------------------------------------------
    wire [7:0] stat0 = {s_sup_uv, s_reg_uv, 4'h0, s_otf, s_otw};
    wire [7:0] stat1 = {engaged_q[1], s_clip[1], s_oc[1], vbat_q > r_inf_q,
                        engaged_q[0], s_clip[0], s_oc[0], vbat_q > l_inf_q};
    logic [7:0] rd_d;
    always_comb begin
        case (reg_addr_i)
            ADDR_L_MODE: rd_d = l_mode_q;
            ADDR_L_THR: rd_d = l_thr_q;
            ADDR_L_INF: rd_d = l_inf_q;
            ADDR_R_MODE: rd_d = r_mode_q;
            ADDR_R_THR: rd_d = r_thr_q;
            ADDR_R_INF: rd_d = r_inf_q;
            ADDR_L_CLIP: rd_d = l_clip_q;
            ADDR_R_CLIP: rd_d = r_clip_q;
            ADDR_OTW_GAIN: rd_d = otw_gain_q;
            ADDR_RECOVERY: rd_d = recov_q;
            ADDR_STATUS0: rd_d = stat0;
            ADDR_STATUS1: rd_d = stat1;
            ADDR_VBAT: rd_d = vbat_q;
            default: rd_d = RST_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= RST_ZERO;
            amp_enable_o <= 1'b0;
            mute_o <= '0;
            left_gain_cut_o <= RST_ZERO;
            right_gain_cut_o <= RST_ZERO;
            left_warning_gain_cut_o <= '0;
            right_warning_gain_cut_o <= '0;
            left_clipper_level_o <= RST_CLIP;
            right_clipper_level_o <= RST_CLIP;
        end else begin
            if (reg_rd_i) reg_rdata_o <= rd_d;
            amp_enable_o <= st_q == FSL_RUN;
            mute_o <= mute_q;
            left_gain_cut_o <= cut_q[0];
            right_gain_cut_o <= cut_q[1];
            left_warning_gain_cut_o <= s_otw ? otw_gain_q[1:0] : 2'b00;
            right_warning_gain_cut_o <= s_otw ? otw_gain_q[B_GAIN_R_LO +: 2] : 2'b00;
            left_clipper_level_o <= l_clip_q;
            right_clipper_level_o <= r_clip_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_manual_down;
        @(posedge ref_clk_i) disable iff (rst_i)
        (st_q == FSL_DOWN && !manual_recovery_request_pulse_q) |=> st_q == FSL_DOWN;
    endproperty
    a_manual_down: assert property (p_manual_down) else $error("Left shutdown");

    property p_manual_recovery_request;
        @(posedge ref_clk_i) disable iff (rst_i)
        (st_q == FSL_DOWN && manual_recovery_request_pulse_q) |=> st_q == FSL_WAIT;
    endproperty
    a_manual_recovery_request: assert property (p_manual_recovery_request) else $error("Manual request ignored");

    property p_status0;
        @(posedge ref_clk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == ADDR_STATUS0
            |=> reg_rdata_o == {$past(s_sup_uv), $past(s_reg_uv), 4'h0,
                                $past(s_otf), $past(s_otw)};
    endproperty
    a_status0: assert property (p_status0) else $error("Status0 wrong");

    property p_ro;
        @(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == ADDR_VBAT |=> $stable(vbat_q) || vbat_q == $past(s_vbat);
    endproperty
    a_ro: assert property (p_ro) else $error("Supply code written");

    property p_off;
        @(posedge ref_clk_i) disable iff (rst_i)
        l_mode_q[1:0] == LIM_OFF |=> !engaged_q[0];
    endproperty
    a_off: assert property (p_off) else $error("Limiter engaged while off");

    property p_otw;
        @(posedge ref_clk_i) disable iff (rst_i)
        !s_otw |=> left_warning_gain_cut_o == 2'b00 && right_warning_gain_cut_o == 2'b00;
    endproperty
    a_otw: assert property (p_otw) else $error("Gain cut without warning");

    property p_mute;
        @(posedge ref_clk_i) disable iff (rst_i)
        mute_q[0] |-> l_mode_q[1:0] == LIM_MUTE_LOW || $past(l_mode_q[1:0]) == LIM_MUTE_LOW;
    endproperty
    a_mute: assert property (p_mute) else $error("Mute in wrong mode");

    property p_retry;
        @(posedge ref_clk_i) disable iff (rst_i)
        (st_q == FSL_WAIT && tries_q != $past(tries_q) && $stable(recov_q))
            |-> tries_q <= retry_max;
    endproperty
    a_retry: assert property (p_retry) else $error("Retry count exceeded");

    property p_amp_off;
        @(posedge ref_clk_i) disable iff (rst_i)
        st_q != FSL_RUN |=> !amp_enable_o;
    endproperty
    a_amp_off: assert property (p_amp_off) else $error("Power stage on in fault");

    property p_otw_on;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_otw |=> left_warning_gain_cut_o == $past(otw_gain_q[1:0]);
    endproperty
    a_otw_on: assert property (p_otw_on) else $error("Warning gain cut missing");
endmodule // fsl_ctrl

/* testbench/fsl_host_model.sv */
// Controller-side model that drives the register port
`timescale 1ns/100ps
module fsl_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Idle bus shows inverted values, so stale address never looks valid
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input int gap);
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
        repeat (gap) @(posedge ref_clk_i);
    endtask
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= addr;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        #1 data = reg_rdata_i;
    endtask
    // Restart after a manual-class fault is up to the controller
    task automatic request_recovery();
        write_reg(fsl_pkg::ADDR_RECOVERY, 8'h80, 0);
    endtask
endmodule // fsl_host_model

/* testbench/fault_status_limiter_ctrl_tb_top.sv */
// Self-checking testbench for the fault status and limiter block
`timescale 1ns/100ps
module fault_status_limiter_ctrl_tb_top;
    import fsl_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] mon_q = 8'h00;
    logic [7:0] vbat_q = 8'h00;
    logic [4:0] lvl_l_q = 5'd0;
    logic [4:0] lvl_r_q = 5'd0;
    logic amp_en;
    logic [1:0] mute, wcut_l, wcut_r;
    logic [7:0] cut_l, cut_r, clip_l, clip_r;
    int miscompares = 0;
    int check_count = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    // ------------------------------------------------------------
    // Design and controller model
    // ------------------------------------------------------------
    fsl_ctrl #(.RETRY_CYCLES(8)) u_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .regulator_uv_i(mon_q[6]), .supply_uv_i(mon_q[7]),
        .overtemp_fault_i(mon_q[5]), .overtemp_warn_i(mon_q[4]),
        .overcurrent_i(mon_q[1:0]), .dac_clip_i(mon_q[3:2]), .vbat_code_i(vbat_q),
        .left_level_i(lvl_l_q), .right_level_i(lvl_r_q),
        .amp_enable_o(amp_en), .mute_o(mute),
        .left_gain_cut_o(cut_l), .right_gain_cut_o(cut_r),
        .left_warning_gain_cut_o(wcut_l), .right_warning_gain_cut_o(wcut_r),
        .left_clipper_level_o(clip_l), .right_clipper_level_o(clip_r)
    );
    fsl_host_model u_host (
        .ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata)
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h got %h", name, exp, got);
        end
    endtask
    task automatic rd_check(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(addr, d);
        check(name, exp, d);
    endtask
    // Bounded wait: retry delay plus sync stages
    task automatic wait_amp(input int limit);
        for (int i = 0; i < limit && amp_en !== 1'b1; i++) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic set_mon(input logic [7:0] m, input int settle);
        @(posedge ref_clk_i);
        mon_q <= m;
        repeat (settle) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic finish_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        rd_check("l_mode", ADDR_L_MODE, RST_L_MODE);
        rd_check("r_mode", ADDR_R_MODE, RST_R_MODE);
        rd_check("l_thr", ADDR_L_THR, RST_THR);
        rd_check("r_inf", ADDR_R_INF, RST_INF);
        rd_check("otw_gain", ADDR_OTW_GAIN, RST_ZERO);
        rd_check("unmapped", 8'h3C, 8'h00);
        check("clip_l", RST_CLIP, clip_l);
        check("amp_en", 8'h01, {7'd0, amp_en});
    endtask
    // One monitor input at a time; mapping spans both status registers
    task automatic test_status_flags();
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            set_mon(m, 5);
            rd_check("status0", ADDR_STATUS0, {m[7], m[6], 4'h0, m[5], m[4]});
            rd_check("stat1", ADDR_STATUS1, {1'b0, m[3], m[1], 2'b00, m[2], m[0], 1'b0});
        end
        set_mon(8'h00, 5);
        u_host.request_recovery();
        wait_amp(60);
    endtask
    task automatic test_readonly_vbat();
        vbat_q <= 8'hA9;
        repeat (6) @(posedge ref_clk_i);
        u_host.write_reg(ADDR_VBAT, 8'h5A, 1);
        u_host.write_reg(ADDR_STATUS0, 8'hFF, 1);
        rd_check("vbat", ADDR_VBAT, 8'hA9);
        rd_check("status0_ro", ADDR_STATUS0, 8'h00);
    endtask
    task automatic test_warning_gain();
        u_host.write_reg(ADDR_OTW_GAIN, 8'h21, 1);
        set_mon(8'h10, 5);
        check("wcut_l", 8'h01, {6'd0, wcut_l});
        check("wcut_r", 8'h02, {6'd0, wcut_r});
        set_mon(8'h00, 5);
        check("wcut_l_off", 8'h00, {6'd0, wcut_l});
        u_host.write_reg(ADDR_R_CLIP, 8'h6B, 2);
        check("clip_r", 8'h6B, clip_r);
    endtask
    task automatic test_manual_recovery();
        u_host.write_reg(ADDR_RECOVERY, 8'h00, 1);
        set_mon(8'h01, 5);
        check("amp_down", 8'h00, {7'd0, amp_en});
        set_mon(8'h00, 40);
        check("amp_stays_down", 8'h00, {7'd0, amp_en});
        u_host.request_recovery();
        wait_amp(60);
        check("amp_manual_up", 8'h01, {7'd0, amp_en});
    endtask
    task automatic test_auto_recovery();
        u_host.write_reg(ADDR_RECOVERY, 8'h31, 1);
        set_mon(8'h02, 5);
        check("amp_auto_down", 8'h00, {7'd0, amp_en});
        set_mon(8'h00, 0);
        wait_amp(60);
        check("amp_auto_up", 8'h01, {7'd0, amp_en});
        // Fault held past all retries: stays down once the count is spent
        set_mon(8'h01, 60);
        set_mon(8'h00, 40);
        check("amp_retry_limit", 8'h00, {7'd0, amp_en});
        u_host.request_recovery();
        wait_amp(60);
        check("amp_retry_up", 8'h01, {7'd0, amp_en});
    endtask
    task automatic test_battery_mute();
        u_host.write_reg(ADDR_L_INF, 8'h80, 0);
        vbat_q <= 8'h90;
        repeat (6) @(posedge ref_clk_i);
        rd_check("bat_flags", ADDR_STATUS1, 8'h11);
        u_host.write_reg(ADDR_L_MODE, 8'h02, 0);
        vbat_q <= 8'h40;
        repeat (8) @(posedge ref_clk_i);
        #1 check("mute_low", 8'h01, {6'd0, mute});
        vbat_q <= 8'h82;
        repeat (8) @(posedge ref_clk_i);
        #1 check("mute_hyst", 8'h01, {6'd0, mute});
        vbat_q <= 8'h90;
        repeat (8) @(posedge ref_clk_i);
        #1 check("mute_high", 8'h00, {6'd0, mute});
    endtask
    // Mode 00 must ignore a loud signal before mode 01 acts on it
    task automatic test_limiter();
        u_host.write_reg(ADDR_L_MODE, 8'h00, 0);
        lvl_l_q <= 5'd31;
        lvl_r_q <= 5'd31;
        repeat (300) @(posedge ref_clk_i);
        #1 check("cut_off_mode", 8'h00, cut_l);
        u_host.write_reg(ADDR_L_THR, 8'h21, 0);
        u_host.write_reg(ADDR_L_MODE, 8'h01, 0);
        repeat (300) @(posedge ref_clk_i);
        #1 check("cut_attack", 8'h01, {7'd0, cut_l != 8'h00});
        check("cut_right_idle", 8'h00, cut_r);
        rd_check("engaged", ADDR_STATUS1, 8'h19);
        lvl_l_q <= 5'd2;
        repeat (6000) @(posedge ref_clk_i);
        #1 check("cut_release", 8'h00, cut_l);
        rd_check("disengaged", ADDR_STATUS1, 8'h11);
        lvl_l_q <= 5'd4;
        rd_check("at_thr", ADDR_STATUS1, 8'h11);
        lvl_l_q <= 5'd5;
        rd_check("above_thr", ADDR_STATUS1, 8'h19);
    endtask
    // Mode 11 below the point: fixed threshold, then tracked one
    task automatic test_tracking();
        u_host.write_reg(ADDR_L_THR, 8'h83, 0);
        u_host.write_reg(ADDR_L_MODE, 8'h03, 0);
        lvl_l_q <= 5'd12;
        vbat_q <= 8'h70;
        repeat (8) @(posedge ref_clk_i);
        rd_check("fixed_low", ADDR_STATUS1, 8'h10);
        u_host.write_reg(ADDR_L_MODE, 8'h07, 0);
        rd_check("tracked_low", ADDR_STATUS1, 8'h18);
        vbat_q <= 8'h90;
        repeat (8) @(posedge ref_clk_i);
        rd_check("tracked_high", ADDR_STATUS1, 8'h11);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        test_reset_values();
        test_status_flags();
        test_readonly_vbat();
        test_warning_gain();
        test_manual_recovery();
        test_auto_recovery();
        test_battery_mute();
        test_limiter();
        test_tracking();
        finish_test();
    end
    initial begin
        #400000;
        miscompares++;
        finish_test();
    end
endmodule // fault_status_limiter_ctrl_tb_top
